/* File: sfpe_host.sv */
// host controller model driving the serial flash link
`timescale 1ns/1ns

module sfpe_host (
	// clock
	input  wire logic       clk,
	// link
	output logic            serial_clock,
	output logic            chip_select_n,
	output logic [3:0]      line,
	input  wire logic [3:0] dev_o,
	input  wire logic [3:0] dev_oe
);
	logic [3:0] host_d;
	logic       oe1_seen;

	initial
	begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		host_d = 4'h0;
		oe1_seen = 1'b0;
	end

	// wire level from the device enables: device drives where enabled, host elsewhere
	assign line = (dev_oe & dev_o) | (~dev_oe & host_d);

	always @(posedge clk)
		if (dev_oe[1])
			oe1_seen <= 1'b1;

	task automatic sel();
		@(negedge clk);
		chip_select_n = 1'b0;
		oe1_seen = 1'b0;
	endtask

	// clock idles low between frames
	task automatic desel();
		@(negedge clk);
		serial_clock = 1'b0;
		repeat (10) @(negedge clk);
		chip_select_n = 1'b1;
		host_d = ~host_d;
		repeat (10) @(negedge clk);
	endtask

	// data set while clock low, line sampled at the rise
	task automatic tick(input logic [3:0] v, output logic [3:0] seen);
		@(negedge clk);
		serial_clock = 1'b0;
		host_d = v;
		repeat (10) @(negedge clk);
		serial_clock = 1'b1;
		seen = line;
		repeat (9) @(negedge clk);
	endtask

	task automatic send(input logic [31:0] v, input int nbits, input int lanes);
		logic [3:0]  s;
		logic [31:0] t;
		t = v << (32 - nbits);
		for (int i = 0; i < nbits / lanes; i++)
		begin
			tick(4'(t[31 -: 4] >> (4 - lanes)), s);
			t = t << lanes;
		end
	endtask

	// released host lines toggle every bit
	task automatic recv(input int lanes, output logic [7:0] b);
		logic [3:0] s;
		b = 8'h00;
		for (int i = 0; i < 8 / lanes; i++)
		begin
			tick(~host_d, s);
			b = (lanes == 1) ? {b[6:0], s[1]} : {b[3:0], s};
		end
	endtask
endmodule

/* File: sfpe_pkg.sv */
// constants of the serial flash program and erase block
package sfpe_pkg;
	localparam int CLK_MHZ = 125;
	localparam int MEM_AW = 16;
	localparam int SECT_AW = 12;
	localparam int PAGE_AW = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int ADDR3_BITS = 24;
	localparam int ADDR4_BITS = 32;
	localparam logic [7:0] ID_CODE = 8'h5a; // arbitrary value
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_DPP = 8'ha2;
	localparam logic [7:0] CMD_QPP = 8'h32;
	localparam logic [7:0] CMD_SE = 8'hd8;
	localparam logic [7:0] CMD_BE = 8'hc7;
	localparam logic [7:0] CMD_FRD = 8'h0b;
	localparam logic [7:0] CMD_QRD = 8'heb;
	localparam logic [7:0] CMD_RDID = 8'hab;
	localparam longint T_WB_US = 600;
	localparam longint T_ES_MS = 700;
	localparam longint T_EB_S = 170;
	localparam longint WB_CYC = T_WB_US * CLK_MHZ;
	localparam longint ES_CYC = T_ES_MS * 1000 * CLK_MHZ;
	localparam longint EB_CYC = T_EB_S * 1000000 * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_CMD = 3'h0, ST_ADDR = 3'h1, ST_DUMMY = 3'h3,
		ST_DOUT = 3'h2, ST_DIN = 3'h6, ST_IGN = 3'h7
	} sfpe_state_e;
	typedef enum logic [2:0] {
		K_NONE, K_WREN, K_PROG, K_SE, K_BE, K_READ, K_ID
	} sfpe_kind_e;
endpackage

/* File: sfpe_top.sv */
// serial flash command, program, erase and read logic with its byte fifo
// Summary of operation
// - quad read moves address and data on four lines
// - four-byte mode takes a 32-bit address
// - id read returns 8 bits on line 1
// - id read ignored while a cycle runs
// - program needs write enable; latch cleared after
// - data past page end wraps in page
// - over 256 bytes keeps last 256
// - unwritten page bytes keep their content
// - select high starts program; busy flag shows
// - dual program takes address, data on two lines
// - quad program takes address, data on four lines
// - bulk erase sets all bits; needs enable
// - bulk erase self-timed, busy, latch cleared early
// - sector erase sets all bits of the addressed sector
// - sector erase self-timed, busy, latch cleared early
// - active while selected or busy, else standby
// - fast read is code, address, dummy, data
// - read address increments and wraps to zero
`timescale 1ns/1ns

module sfpe_fifo #(
	parameter int W = 8,
	parameter int D = 32
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready = (cnt_ff != (AW+1)'(D));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rp_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_ff] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wp_ff <= push ? wp_ff + 1'b1 : wp_ff;
			rp_ff <= pop ? rp_ff + 1'b1 : rp_ff;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module sfpe_top #(
	parameter logic [7:0]  P_WREN = sfpe_pkg::CMD_WREN,
	parameter logic [7:0]  P_PP = sfpe_pkg::CMD_PP,
	parameter logic [7:0]  P_DPP = sfpe_pkg::CMD_DPP,
	parameter logic [7:0]  P_QPP = sfpe_pkg::CMD_QPP,
	parameter logic [7:0]  P_SE = sfpe_pkg::CMD_SE,
	parameter logic [7:0]  P_BE = sfpe_pkg::CMD_BE,
	parameter logic [7:0]  P_FRD = sfpe_pkg::CMD_FRD,
	parameter logic [7:0]  P_QRD = sfpe_pkg::CMD_QRD,
	parameter logic [7:0]  P_RDID = sfpe_pkg::CMD_RDID,
	parameter logic [39:0] PROG_CYC = 40'(sfpe_pkg::WB_CYC),
	parameter logic [39:0] SECT_CYC = 40'(sfpe_pkg::ES_CYC),
	parameter logic [39:0] BULK_CYC = 40'(sfpe_pkg::EB_CYC)
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// serial link
	input  wire logic serial_clock,
	input  wire logic chip_select_n,
	input  wire logic serial_io_0_i,
	output logic      serial_io_0_o,
	output logic      serial_io_0_oe,
	input  wire logic serial_io_1_i,
	output logic      serial_io_1_o,
	output logic      serial_io_1_oe,
	input  wire logic serial_io_2_i,
	output logic      serial_io_2_o,
	output logic      serial_io_2_oe,
	input  wire logic serial_io_3_i,
	output logic      serial_io_3_o,
	output logic      serial_io_3_oe,
	// configuration
	input  wire logic addr4_mode,
	// status
	output logic      write_in_progress,
	output logic      write_enable_latch,
	output logic      active_mode,
	output logic      rx_ready
);
	import sfpe_pkg::*;

	logic [2:0]   sck_q;
	logic [2:0]   csn_q;
	logic [3:0]   io_m;
	logic [3:0]   io_s;
	sfpe_state_e  st_ff;
	sfpe_kind_e   kind_ff;
	sfpe_kind_e   dec_kind;
	sfpe_kind_e   job_ff;
	logic [2:0]   lanes_ff;
	logic [2:0]   dec_lanes;
	logic [5:0]   cnt_ff;
	logic [5:0]   nxt_cnt;
	logic [31:0]  sh_ff;
	logic [31:0]  nxt_sh;
	logic [31:0]  addr_ff;
	logic         arm_ff;
	logic         push_ff;
	logic [7:0]   push_d_ff;
	logic [3:0]   io_o_ff;
	logic [3:0]   io_oe_ff;
	logic [7:0]   osh_ff;
	logic [3:0]   ocnt_ff;
	logic [MEM_AW-1:0] raddr_ff;
	logic [7:0]   out_byte;
	logic [7:0]   mem [2**MEM_AW];
	logic [7:0]   pbuf [2**PAGE_AW];
	logic [255:0] pval_ff;
	logic [7:0]   pidx_ff;
	logic         wip_ff;
	logic         wel_ff;
	logic         active_ff;
	logic         rdy_ff;
	logic         walk_ff;
	logic [39:0]  tmr_ff;
	logic [MEM_AW:0] wcnt_ff;
	logic [MEM_AW:0] wlim;
	logic [MEM_AW-1:0] mem_wa;
	logic         mem_we;
	logic         wdone;
	logic         sck_rise;
	logic         sck_fall;
	logic         cs_rise;
	logic         ev_cmd;
	logic         ev_adr;
	logic         f_in_rdy;
	logic         f_out_vld;
	logic [7:0]   f_out_d;
	logic         pop;
	logic         start;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sck_q <= 3'h0;
			csn_q <= 3'h7;
			io_m <= 4'h0;
			io_s <= 4'h0;
		end
		else
		begin
			sck_q <= {sck_q[1:0], serial_clock};
			csn_q <= {csn_q[1:0], chip_select_n};
			io_m <= {serial_io_3_i, serial_io_2_i, serial_io_1_i, serial_io_0_i};
			io_s <= io_m;
		end
	end

	assign sck_rise = sck_q[1] & ~sck_q[2] & ~csn_q[1];
	assign sck_fall = ~sck_q[1] & sck_q[2] & ~csn_q[1];
	assign cs_rise = csn_q[1] & ~csn_q[2];
	// msb first, lanes wide per rising edge
	always_comb
	begin
		nxt_sh = {sh_ff[30:0], io_s[0]};
		if (lanes_ff == 3'd4)
			nxt_sh = {sh_ff[27:0], io_s};
		else if (lanes_ff == 3'd2)
			nxt_sh = {sh_ff[29:0], io_s[1:0]};
	end
	assign nxt_cnt = cnt_ff + 6'(lanes_ff);
	assign ev_cmd = sck_rise & (st_ff == ST_CMD) & (cnt_ff == 6'd7);
	assign ev_adr = sck_rise & (st_ff == ST_ADDR)
		& (nxt_cnt == (addr4_mode ? 6'(ADDR4_BITS) : 6'(ADDR3_BITS)));

	always_comb
	begin
		dec_kind = K_NONE;
		dec_lanes = 3'd1;
		case (nxt_sh[7:0])
			P_WREN: dec_kind = K_WREN;
			P_PP: dec_kind = K_PROG;
			P_DPP:
			begin
				dec_kind = K_PROG;
				dec_lanes = 3'd2;
			end
			P_QPP:
			begin
				dec_kind = K_PROG;
				dec_lanes = 3'd4;
			end
			P_SE: dec_kind = K_SE;
			P_BE: dec_kind = K_BE;
			P_FRD: dec_kind = K_READ;
			P_QRD:
			begin
				dec_kind = K_READ;
				dec_lanes = 3'd4;
			end
			P_RDID: dec_kind = K_ID;
			default: dec_kind = K_NONE;
		endcase
	end

	// command, address and data-in sequencer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_ff <= ST_CMD;
			kind_ff <= K_NONE;
			lanes_ff <= 3'd1;
			cnt_ff <= '0;
			sh_ff <= '0;
			addr_ff <= '0;
			arm_ff <= 1'b0;
			push_ff <= 1'b0;
			push_d_ff <= '0;
		end
		else
		begin
			push_ff <= 1'b0;
			if (csn_q[1])
			begin
				st_ff <= ST_CMD;
				lanes_ff <= 3'd1;
				cnt_ff <= '0;
				arm_ff <= 1'b0;
			end
			else if (sck_rise)
			begin
				sh_ff <= nxt_sh;
				cnt_ff <= nxt_cnt;
				case (st_ff)
					ST_CMD:
					if (cnt_ff == 6'd7)
					begin
						kind_ff <= dec_kind;
						lanes_ff <= dec_lanes;
						cnt_ff <= '0;
						st_ff <= ST_IGN;
						if (wip_ff)
							st_ff <= ST_IGN;
						else if (dec_kind == K_BE)
							arm_ff <= wel_ff;
						else if (dec_kind == K_ID)
							st_ff <= ST_DOUT;
						else if (dec_kind == K_READ)
							st_ff <= ST_ADDR;
						else if ((dec_kind == K_PROG || dec_kind == K_SE) && wel_ff)
							st_ff <= ST_ADDR;
					end
					ST_ADDR:
					if (ev_adr)
					begin
						addr_ff <= nxt_sh;
						cnt_ff <= '0;
						st_ff <= (kind_ff == K_READ) ? ST_DUMMY
							: (kind_ff == K_PROG) ? ST_DIN : ST_IGN;
						arm_ff <= (kind_ff == K_SE);
					end
					ST_DUMMY:
					if (nxt_cnt == 6'd8)
						st_ff <= ST_DOUT;
					ST_DIN:
					if (nxt_cnt == 6'd8)
					begin
						cnt_ff <= '0;
						push_ff <= 1'b1;
						push_d_ff <= nxt_sh[7:0];
						arm_ff <= 1'b1;
					end
					default: cnt_ff <= cnt_ff;
				endcase
			end
		end
	end

	assign out_byte = (kind_ff == K_ID) ? ID_CODE : mem[raddr_ff];

	// data out, changed on falling edges
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			io_o_ff <= 4'h0;
			io_oe_ff <= 4'h0;
			osh_ff <= '0;
			ocnt_ff <= '0;
			raddr_ff <= '0;
		end
		else if (csn_q[1] || st_ff != ST_DOUT)
		begin
			io_oe_ff <= 4'h0;
			ocnt_ff <= '0;
			if (ev_adr)
				raddr_ff <= nxt_sh[MEM_AW-1:0];
		end
		else if (sck_fall)
		begin
			if (lanes_ff == 3'd4)
			begin
				io_oe_ff <= 4'hf;
				io_o_ff <= (ocnt_ff == 4'd0) ? out_byte[7:4] : osh_ff[7:4];
				osh_ff <= (ocnt_ff == 4'd0) ? {out_byte[3:0], 4'h0} : {osh_ff[3:0], 4'h0};
			end
			else
			begin
				io_oe_ff <= 4'h2;
				io_o_ff <= {2'b00, (ocnt_ff == 4'd0) ? out_byte[7] : osh_ff[7], 1'b0};
				osh_ff <= (ocnt_ff == 4'd0) ? {out_byte[6:0], 1'b0} : {osh_ff[6:0], 1'b0};
			end
			if (ocnt_ff == 4'd0)
			begin
				ocnt_ff <= 4'd8 - 4'(lanes_ff);
				if (kind_ff == K_READ)
					raddr_ff <= raddr_ff + 1'b1;
			end
			else
				ocnt_ff <= ocnt_ff - 4'(lanes_ff);
		end
	end

	sfpe_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push_ff),
		.in_ready  (f_in_rdy),
		.in_data   (push_d_ff),
		.out_valid (f_out_vld),
		.out_ready (~walk_ff),
		.out_data  (f_out_d)
	);

	assign pop = f_out_vld & ~walk_ff;

	// page buffer, offset wraps inside the page
	always_ff @(posedge clk)
	begin
		if (pop)
			pbuf[pidx_ff] <= f_out_d;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pidx_ff <= '0;
			pval_ff <= '0;
		end
		else if (ev_adr)
		begin
			pidx_ff <= nxt_sh[7:0];
			pval_ff <= '0;
		end
		else if (pop)
		begin
			pidx_ff <= pidx_ff + 8'd1;
			pval_ff[pidx_ff] <= 1'b1;
		end
	end

	assign start = cs_rise & arm_ff & ~wip_ff;
	assign wlim = (job_ff == K_PROG) ? (MEM_AW+1)'(2**PAGE_AW)
		: (job_ff == K_SE) ? (MEM_AW+1)'(2**SECT_AW) : (MEM_AW+1)'(2**MEM_AW);
	assign wdone = (wcnt_ff == wlim);
	always_comb
	begin
		mem_wa = wcnt_ff[MEM_AW-1:0];
		if (job_ff == K_PROG)
			mem_wa = {addr_ff[MEM_AW-1:PAGE_AW], wcnt_ff[PAGE_AW-1:0]};
		else if (job_ff == K_SE)
			mem_wa = {addr_ff[MEM_AW-1:SECT_AW], wcnt_ff[SECT_AW-1:0]};
	end
	assign mem_we = walk_ff & ~wdone & ((job_ff != K_PROG) | pval_ff[wcnt_ff[7:0]]);

	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_wa] <= (job_ff == K_PROG)
				? (mem[mem_wa] & pbuf[wcnt_ff[7:0]]) : 8'hff;
	end

	// self-timed program and erase cycles
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wip_ff <= 1'b0;
			walk_ff <= 1'b0;
			job_ff <= K_NONE;
			tmr_ff <= '0;
			wcnt_ff <= '0;
		end
		else if (start)
		begin
			wip_ff <= 1'b1;
			job_ff <= kind_ff;
			wcnt_ff <= '0;
			tmr_ff <= (kind_ff == K_PROG) ? PROG_CYC
				: (kind_ff == K_SE) ? SECT_CYC : BULK_CYC;
		end
		else if (wip_ff)
		begin
			if (tmr_ff != '0)
				tmr_ff <= tmr_ff - 40'd1;
			if (!walk_ff && !f_out_vld)
				walk_ff <= 1'b1;
			else if (walk_ff && !wdone)
				wcnt_ff <= wcnt_ff + 1'b1;
			if (walk_ff && wdone && tmr_ff == '0)
			begin
				wip_ff <= 1'b0;
				walk_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wel_ff <= 1'b0;
		else if (ev_cmd && dec_kind == K_WREN && !wip_ff)
			wel_ff <= 1'b1;
		else if (start && kind_ff != K_PROG)
			wel_ff <= 1'b0;
		else if (wip_ff && job_ff == K_PROG && walk_ff && wdone && tmr_ff == '0)
			wel_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			active_ff <= 1'b0;
			rdy_ff <= 1'b1;
		end
		else
		begin
			active_ff <= ~csn_q[1] | wip_ff | start;
			rdy_ff <= f_in_rdy;
		end
	end

	assign serial_io_0_o = io_o_ff[0];
	assign serial_io_1_o = io_o_ff[1];
	assign serial_io_2_o = io_o_ff[2];
	assign serial_io_3_o = io_o_ff[3];
	assign serial_io_0_oe = io_oe_ff[0];
	assign serial_io_1_oe = io_oe_ff[1];
	assign serial_io_2_oe = io_oe_ff[2];
	assign serial_io_3_oe = io_oe_ff[3];
	assign write_in_progress = wip_ff;
	assign write_enable_latch = wel_ff;
	assign active_mode = active_ff;
	assign rx_ready = rdy_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_wip_start: assert property (start |=> wip_ff)
		else $error("busy not raised at select rise");
	a_busy_ignore: assert property (ev_cmd && wip_ff |=> st_ff == ST_IGN)
		else $error("command taken while busy");
	a_no_wel_ign: assert property (ev_cmd && !wip_ff && !wel_ff
		&& dec_kind == K_PROG |=> st_ff == ST_IGN)
		else $error("program taken without enable");
	a_prog_wel_clr: assert property ($fell(wip_ff) && job_ff == K_PROG |-> !wel_ff)
		else $error("latch set after program");
	a_erase_wel: assert property (wip_ff && job_ff != K_PROG |-> !wel_ff)
		else $error("latch set during erase");
	a_page_wrap: assert property (pop && !ev_adr |=> pidx_ff == $past(pidx_ff) + 8'd1)
		else $error("page offset wrong");
	a_active_busy: assert property (!csn_q[1] || wip_ff |=> active_ff)
		else $error("standby while selected or busy");
	a_id_line: assert property (sck_fall && st_ff == ST_DOUT && kind_ff == K_ID
		|=> io_oe_ff == 4'h2)
		else $error("id not on line 1");
	a_quad_out: assert property (sck_fall && st_ff == ST_DOUT && lanes_ff == 3'd4
		|=> io_oe_ff == 4'hf)
		else $error("quad read not on four lines");
endmodule

/* File: tb.sv */
// self-checking bench of the serial flash program and erase block
`timescale 1ns/1ns

module tb;
	import sfpe_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       a4;
	logic       serial_clock;
	logic       chip_select_n;
	logic [3:0] line;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic       write_in_progress;
	logic       write_enable_latch;
	logic       active_mode;
	logic       rx_ready;
	logic [7:0] b;
	logic [7:0] q[$];
	int         errors;
	int         samples_checked;
	int         cycles;

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	sfpe_top #(.PROG_CYC(40'h12c), .SECT_CYC(40'h1388), .BULK_CYC(40'h11170)) uut (
		.clk               (clk),
		.rst_n             (rst_n),
		.serial_clock      (serial_clock),
		.chip_select_n     (chip_select_n),
		.serial_io_0_i     (line[0]),
		.serial_io_0_o     (dev_o[0]),
		.serial_io_0_oe    (dev_oe[0]),
		.serial_io_1_i     (line[1]),
		.serial_io_1_o     (dev_o[1]),
		.serial_io_1_oe    (dev_oe[1]),
		.serial_io_2_i     (line[2]),
		.serial_io_2_o     (dev_o[2]),
		.serial_io_2_oe    (dev_oe[2]),
		.serial_io_3_i     (line[3]),
		.serial_io_3_o     (dev_o[3]),
		.serial_io_3_oe    (dev_oe[3]),
		.addr4_mode        (a4),
		.write_in_progress (write_in_progress),
		.write_enable_latch(write_enable_latch),
		.active_mode       (active_mode),
		.rx_ready          (rx_ready)
	);

	sfpe_host host (
		.clk          (clk),
		.serial_clock (serial_clock),
		.chip_select_n(chip_select_n),
		.line         (line),
		.dev_o        (dev_o),
		.dev_oe       (dev_oe)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 80000)
		begin
			errors++;
			$display("MISMATCH timeout expected done seen hang");
			report_and_stop();
		end
	end

	task automatic wren();
		host.sel();
		host.send(32'(CMD_WREN), 8, 1);
		host.desel();
		chk("latch", 8'(write_enable_latch), 8'h01);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 20000 && write_in_progress !== 1'b0; i++)
			@(negedge clk);
		chk("busy", 8'(write_in_progress), 8'h00);
	endtask

	task automatic prog(input logic [7:0] cmd, input int lanes, input logic [31:0] addr,
		input logic [7:0] d[$]);
		wren();
		host.sel();
		host.send(32'(cmd), 8, 1);
		host.send(addr, 24, lanes);
		foreach (d[i])
			host.send(32'(d[i]), 8, lanes);
		host.desel();
		chk("busy", 8'(write_in_progress), 8'h01);
		wait_idle();
		chk("latch", 8'(write_enable_latch), 8'h00);
	endtask

	task automatic rd(input logic [7:0] cmd, input int lanes, input logic [31:0] addr,
		input logic [7:0] e[$]);
		host.sel();
		host.send(32'(cmd), 8, 1);
		host.send(addr, 24, lanes);
		host.send(32'h0, 8, lanes);
		foreach (e[i])
		begin
			host.recv(lanes, b);
			chk("read", b, e[i]);
		end
		host.desel();
	endtask

	initial
	begin
		rst_n = 1'b0;
		a4 = 1'b0;
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (8) @(negedge clk);
		chk("busy", 8'(write_in_progress), 8'h00);
		chk("active", 8'(active_mode), 8'h00);
		chk("room", 8'(rx_ready), 8'h01);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		host.sel();
		host.send(32'(CMD_RDID), 8, 1);
		host.recv(1, b);
		chk("id", b, ID_CODE);
		chk("active", 8'(active_mode), 8'h01);
		host.desel();
		chk("active", 8'(active_mode), 8'h00);
		host.sel();
		host.send(32'(CMD_PP), 8, 1);
		host.send(32'h10, 32, 1);
		host.desel();
		chk("busy", 8'(write_in_progress), 8'h00);
		host.sel();
		host.send(32'(CMD_BE), 8, 1);
		host.desel();
		chk("busy", 8'(write_in_progress), 8'h00);
		$display("test id and refusal done");
		wren();
		a4 = 1'b1;
		host.sel();
		host.send(32'(CMD_SE), 8, 1);
		host.send(32'h0000_0010, 32, 1);
		host.desel();
		a4 = 1'b0;
		chk("busy", 8'(write_in_progress), 8'h01);
		chk("latch", 8'(write_enable_latch), 8'h00);
		chk("active", 8'(active_mode), 8'h01);
		host.sel();
		host.send(32'(CMD_RDID), 8, 1);
		host.recv(1, b);
		host.desel();
		chk("id oe", 8'(host.oe1_seen), 8'h00);
		chk("busy", 8'(write_in_progress), 8'h01);
		wait_idle();
		@(negedge clk);
		chk("active", 8'(active_mode), 8'h00);
		$display("test sector erase done");
		prog(CMD_PP, 1, 32'hfe, '{8'h11, 8'h22, 8'h33});
		prog(CMD_DPP, 2, 32'h300, '{8'h96});
		prog(CMD_QPP, 4, 32'h200, '{8'ha5, 8'h3c});
		q = '{8'h0f, 8'h0f};
		repeat (256) q.push_back(8'hf0);
		prog(CMD_QPP, 4, 32'h400, q);
		$display("test programs done");
		rd(CMD_FRD, 1, 32'hfe, '{8'h11, 8'h22, 8'hff});
		rd(CMD_FRD, 1, 32'h0, '{8'h33, 8'hff});
		rd(CMD_QRD, 4, 32'h1ff, '{8'hff, 8'ha5, 8'h3c, 8'hff});
		rd(CMD_FRD, 1, 32'h2ff, '{8'hff, 8'h96, 8'hff});
		rd(CMD_FRD, 1, 32'h3ff, '{8'hff, 8'hf0, 8'hf0});
		$display("test reads done");
		wren();
		host.sel();
		host.send(32'(CMD_SE), 8, 1);
		host.send(32'hfff0, 24, 1);
		host.desel();
		chk("busy", 8'(write_in_progress), 8'h01);
		wait_idle();
		rd(CMD_FRD, 1, 32'hffff, '{8'hff, 8'h33});
		$display("test read wrap done");
		report_and_stop();
	end
endmodule
